// [src/ccp_pkg.sv]
/*
 * Shared constants and types for the capture/compare/PWM unit.
 * Assumes a single system clock; all inputs are synchronous to it.
 */
package ccp_pkg;
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SWI = 4'ha;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
   localparam int MODE_FIELD_W = 4;
   localparam int PWM_SEL_HI = 3;
   localparam int PWM_SEL_LO = 2;
   localparam int TIMEBASE_W = 16;
   localparam int DUTY_W = 10;
   localparam logic [3:0] PRESC_DIV4_LAST = 4'h3;
   localparam logic [3:0] PRESC_DIV16_LAST = 4'hf;
   localparam logic [3:0] PRESC_RESET = 4'h0;
   localparam logic [15:0] CAPTURE_RESET = 16'h0000;
   localparam logic [9:0] DUTY_RESET = 10'h000;
   localparam logic PIN_RESET = 1'b0;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_COMPARE = 2'b11,
      ST_PWM = 2'b10
   } unit_state_t;

   typedef struct packed {
      logic [3:0] unit_mode_field;
      logic [1:0] duty_low_bits;
      logic [7:0] duty_high_byte;
   } unit_cfg_t;

   typedef struct packed {
      logic capture_event;
      logic match_event;
      logic timer_clear;
      logic adc_start;
   } unit_events_t;
endpackage

// [src/edge_prescaler.sv]
/*
 * Rising-edge prescaler: emits one pulse per 4 or 16 counted edges.
 * Assumes edge_i is already a one-cycle pulse from the caller.
 */
`timescale 1ns/1ps
module edge_prescaler (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic clear_i,
   input wire logic edge_i,
   input wire logic div16_i,
   output logic fire_o
);
   logic [3:0] count;
   logic [3:0] next_count;
   logic [3:0] last;

   always_comb begin
      last = div16_i ? ccp_pkg::PRESC_DIV16_LAST : ccp_pkg::PRESC_DIV4_LAST;
      next_count = count;
      fire_o = 1'b0;
      if (clear_i) begin
         next_count = ccp_pkg::PRESC_RESET;
      end else if (edge_i) begin
         if (count >= last) begin
            next_count = ccp_pkg::PRESC_RESET;
            fire_o = 1'b1;
         end else begin
            next_count = count + 4'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count <= ccp_pkg::PRESC_RESET;
      end else begin
         count <= next_count;
      end
   end
endmodule // edge_prescaler

// [src/ccp_mode_select_decode.sv]
/*
 * Mode decoder and mode-dependent behaviour of one capture/compare/PWM unit.
 * Assumes the timebase timer, the PWM counter and the converter are outside;
 * all inputs are synchronous to clock_i.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Mode 0110 captures the timebase once per four rising pin edges.
// - Mode 0111 captures the timebase once per sixteen rising pin edges.
// - Mode 1000 drives the pin high on compare match and sets the flag.
// - Mode 1001 drives the pin low on compare match and sets the flag.
// - Mode 1010 only sets the flag on match; pin stays as it was.
// - Mode 1011 sets the flag, leaves the pin, clears the timebase timer.
// - Second unit also starts a conversion on special event if converter enabled.
// - Mode 0000 disables the unit and clears its capture, pin and duty; the flag is kept.
// - Mode 0100 captures every falling edge, 0101 every rising edge.
// - PWM duty is ten bits: high byte above the two low bits.
module ccp_mode_select_decode #(
   parameter bit IS_SECOND_UNIT = 1'b0
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire ccp_pkg::unit_cfg_t cfg_i,
   input wire logic [15:0] timebase_timer_i,
   input wire logic [15:0] compare_value_i,
   input wire logic [9:0] pwm_count_i,
   input wire logic unit_io_pin_i,
   input wire logic adc_enabled_i,
   input wire logic flag_clear_i,
   output logic [15:0] capture_value_o,
   output logic unit_match_flag_o,
   output logic unit_io_pin_o,
   output logic unit_io_pin_oe_o,
   output ccp_pkg::unit_events_t events_o,
   output logic [9:0] pwm_duty_o
);
   ccp_pkg::unit_state_t state;
   ccp_pkg::unit_state_t next_state;
   logic pin_prev;
   logic next_pin_prev;
   logic eq_prev;
   logic next_eq_prev;
   logic pin_out;
   logic next_pin_out;
   logic flag;
   logic next_flag;
   logic [15:0] capture;
   logic [15:0] next_capture;
   logic [9:0] duty;
   logic [9:0] next_duty;
   logic rise;
   logic fall;
   logic presc_fire;
   logic presc_clear;
   logic match;
   logic equal_now;
   logic take;
   logic [3:0] mode;
   ccp_pkg::unit_events_t ev;

   function automatic ccp_pkg::unit_state_t decode_mode(input logic [3:0] m);
      if (m[ccp_pkg::PWM_SEL_HI] && m[ccp_pkg::PWM_SEL_LO]) begin
         decode_mode = ccp_pkg::ST_PWM;
      end else if (m[ccp_pkg::PWM_SEL_HI]) begin
         decode_mode = ccp_pkg::ST_COMPARE;
      end else if (m[ccp_pkg::PWM_SEL_LO]) begin
         decode_mode = ccp_pkg::ST_CAPTURE;
      end else begin
         decode_mode = ccp_pkg::ST_OFF;
      end
   endfunction

   assign mode = cfg_i.unit_mode_field;
   assign rise = unit_io_pin_i & ~pin_prev;
   assign fall = ~unit_io_pin_i & pin_prev;
   // Prescaler restarts whenever the mode leaves its divided capture settings
   assign presc_clear = (state != ccp_pkg::ST_CAPTURE) ||
                        (mode != ccp_pkg::MODE_CAP_RISE4 && mode != ccp_pkg::MODE_CAP_RISE16);

   edge_prescaler u_presc (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .clear_i(presc_clear),
      .edge_i(rise),
      .div16_i(mode == ccp_pkg::MODE_CAP_RISE16),
      .fire_o(presc_fire)
   );

   // Match acts on the first cycle of equality so a timer held still fires once
   assign equal_now = (timebase_timer_i == compare_value_i);
   assign match = (state == ccp_pkg::ST_COMPARE) && (mode[3:2] == 2'b10) &&
                  equal_now && !eq_prev;

   always_comb begin
      take = 1'b0;
      if (state == ccp_pkg::ST_CAPTURE) begin
         unique case (mode)
            ccp_pkg::MODE_CAP_FALL: take = fall;
            ccp_pkg::MODE_CAP_RISE: take = rise;
            ccp_pkg::MODE_CAP_RISE4: take = presc_fire;
            ccp_pkg::MODE_CAP_RISE16: take = presc_fire;
            default: take = 1'b0;
         endcase
      end
   end

   always_comb begin
      ev.capture_event = take;
      ev.match_event = match;
      ev.timer_clear = match && (mode == ccp_pkg::MODE_CMP_SPECIAL);
      ev.adc_start = ev.timer_clear && IS_SECOND_UNIT && adc_enabled_i;
   end

   // Mode group: the state register follows the decoded mode one edge late; within a group a new mode acts at once
   always_comb begin
      next_state = decode_mode(mode);
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= ccp_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // History group: last pin level and last equality, for the edge detectors
   always_comb begin
      next_pin_prev = unit_io_pin_i;
      next_eq_prev = equal_now;
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_prev <= 1'b0;
         eq_prev <= 1'b0;
      end else begin
         pin_prev <= next_pin_prev;
         eq_prev <= next_eq_prev;
      end
   end

   // Flag group: turning the unit off leaves the flag for software to clear
   always_comb begin
      next_flag = flag;
      if (flag_clear_i) begin
         next_flag = 1'b0;
      end
      // Set after the clear so an event in the clearing cycle survives
      if (take || match) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   // Capture group: holds the last captured timebase until the next capture; cleared while the unit is off
   always_comb begin
      next_capture = capture;
      if (state == ccp_pkg::ST_OFF) begin
         next_capture = ccp_pkg::CAPTURE_RESET;
      end else if (take) begin
         next_capture = timebase_timer_i;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         capture <= ccp_pkg::CAPTURE_RESET;
      end else begin
         capture <= next_capture;
      end
   end

   // Output group: pin level and latched duty
   always_comb begin
      next_pin_out = pin_out;
      next_duty = duty;
      unique case (state)
         ccp_pkg::ST_OFF: begin
            next_pin_out = ccp_pkg::PIN_RESET;
            next_duty = ccp_pkg::DUTY_RESET;
         end
         ccp_pkg::ST_CAPTURE: begin
         end
         ccp_pkg::ST_COMPARE: begin
            if (match && mode == ccp_pkg::MODE_CMP_SET) begin
               next_pin_out = 1'b1;
            end else if (match && mode == ccp_pkg::MODE_CMP_CLR) begin
               next_pin_out = 1'b0;
            end
         end
         ccp_pkg::ST_PWM: begin
            next_duty = {cfg_i.duty_high_byte, cfg_i.duty_low_bits};
            // Compares with the duty latched last cycle, so a new duty shows one cycle late
            next_pin_out = (pwm_count_i < duty);
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_out <= ccp_pkg::PIN_RESET;
         duty <= ccp_pkg::DUTY_RESET;
      end else begin
         pin_out <= next_pin_out;
         duty <= next_duty;
      end
   end

   assign capture_value_o = capture;
   assign unit_match_flag_o = flag;
   assign unit_io_pin_o = pin_out;
   // Pin is driven only while comparing with a pin action or in PWM
   assign unit_io_pin_oe_o = (state == ccp_pkg::ST_PWM) ||
                             ((state == ccp_pkg::ST_COMPARE) && (mode[3:1] == 3'b100));
   assign events_o = ev;
   assign pwm_duty_o = duty;
endmodule // ccp_mode_select_decode

// [testbench/ccp_far_side.sv]
/* Far-side model: timebase timer and free-running PWM counter.
   Assumes timer_clear_i is the unit's one-cycle special-event pulse. */
`timescale 1ns/1ps
module ccp_far_side (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic timer_clear_i,
   output logic [15:0] timer_o,
   output logic [9:0] pwm_count_o
);
   // Clear lands one edge after the pulse, as a real timer reset does
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer_o <= 16'h0000;
         pwm_count_o <= 10'h000;
      end else begin
         timer_o <= timer_clear_i ? 16'h0000 : timer_o + 16'h0001;
         pwm_count_o <= pwm_count_o + 10'h001;
      end
   end
endmodule // ccp_far_side

// [testbench/ccp_mode_select_decode_asserts.sv]
/* Port checker for one capture/compare/PWM unit.
   Assumes it is bound to every ccp_mode_select_decode instance. */
`timescale 1ns/1ps
module ccp_mode_select_decode_asserts #(
   parameter bit IS_SECOND_UNIT = 1'b0
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire ccp_pkg::unit_cfg_t cfg_i,
   input wire logic [15:0] timebase_timer_i,
   input wire logic [15:0] compare_value_i,
   input wire logic [9:0] pwm_count_i,
   input wire logic unit_io_pin_i,
   input wire logic adc_enabled_i,
   input wire logic flag_clear_i,
   input wire logic [15:0] capture_value_o,
   input wire logic unit_match_flag_o,
   input wire logic unit_io_pin_o,
   input wire logic unit_io_pin_oe_o,
   input wire ccp_pkg::unit_events_t events_o,
   input wire logic [9:0] pwm_duty_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);
   wire logic [3:0] md = cfg_i.unit_mode_field;
   wire logic mt = events_o.match_event;
   wire logic pwm = md[3] && md[2];
   a_cap_value: assert property (events_o.capture_event |=> unit_match_flag_o &&
      capture_value_o == $past(timebase_timer_i)) else $error("capture value wrong");
   a_fall_only: assert property (events_o.capture_event && md == 4'h4 |->
      !unit_io_pin_i && $past(unit_io_pin_i)) else $error("capture off the fall");
   a_rise_only: assert property (events_o.capture_event && md > 4'h4 |->
      unit_io_pin_i && !$past(unit_io_pin_i)) else $error("capture off the rise");
   a_set_high: assert property (mt && md == 4'h8 |=>
      unit_io_pin_o && unit_match_flag_o) else $error("pin not set on match");
   a_set_low: assert property (mt && md == 4'h9 |=>
      !unit_io_pin_o && unit_match_flag_o) else $error("pin not cleared on match");
   a_pin_kept: assert property (mt && md[3:1] == 3'h5 ##1 md[3:1] == 3'h5 |->
      $stable(unit_io_pin_o) && unit_match_flag_o) else $error("pin moved on match");
   a_special_evt: assert property (events_o.timer_clear == (mt && md == 4'hb) &&
      events_o.adc_start == (mt && md == 4'hb && IS_SECOND_UNIT && adc_enabled_i))
      else $error("special event wrong");
   a_pwm_drive: assert property (pwm ##1 pwm |-> unit_io_pin_oe_o)
      else $error("pin not driven in pwm");
   a_pwm_duty: assert property (pwm ##1 pwm |=> pwm_duty_o ==
      {$past(cfg_i.duty_high_byte), $past(cfg_i.duty_low_bits)}) else $error("duty wrong");
   a_off_clear: assert property (md == 4'h0 ##1 md == 4'h0 |=> !unit_io_pin_o &&
      capture_value_o == 16'h0000 && pwm_duty_o == 10'h000) else $error("off not cleared");
   c_capture16: cover property (events_o.capture_event && md == 4'h7);
   c_special: cover property (events_o.adc_start);
   c_pwm: cover property (pwm ##1 pwm);
endmodule // ccp_mode_select_decode_asserts

bind ccp_mode_select_decode ccp_mode_select_decode_asserts #(.IS_SECOND_UNIT(IS_SECOND_UNIT))
   u_check (.clock_i, .arst_n_i, .cfg_i, .timebase_timer_i, .compare_value_i, .pwm_count_i,
   .unit_io_pin_i, .adc_enabled_i, .flag_clear_i, .capture_value_o, .unit_match_flag_o,
   .unit_io_pin_o, .unit_io_pin_oe_o, .events_o, .pwm_duty_o);

// [testbench/ccp_mode_select_decode_test.sv]
/* Self-checking bench for the second capture/compare/PWM unit.
   Assumes the far-side model supplies the timebase and the PWM count. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module ccp_mode_select_decode_test;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   ccp_pkg::unit_cfg_t cfg_i = '0;
   logic [15:0] compare_value_i = 16'h0000;
   logic unit_io_pin_i = 1'b0;
   logic adc_enabled_i = 1'b0;
   logic flag_clear_i = 1'b0;
   logic [15:0] timebase_timer_i, capture_value_o, capv;
   logic [9:0] pwm_count_i, pwm_duty_o, duty;
   logic unit_match_flag_o, unit_io_pin_o, unit_io_pin_oe_o, ppin, peq, cap, mt, flg, pin;
   ccp_pkg::unit_events_t events_o;
   ccp_pkg::unit_events_t first_events;
   logic [3:0] evx;
   int n_mismatch = 0;
   int n_checks = 0;
   int st, presc, m;
   logic [31:0] seed = 32'h40198fbc;
   logic [31:0] r;
   // Mode 7 follows 6 so a partial divide-by-sixteen count never meets a 4 limit
   logic [3:0] modes[14] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc,
      4'hf, 4'hd, 4'h1, 4'h0};
   ccp_far_side far (.clock_i, .arst_n_i, .timer_clear_i(events_o.timer_clear),
      .timer_o(timebase_timer_i), .pwm_count_o(pwm_count_i));
   ccp_mode_select_decode #(.IS_SECOND_UNIT(1'b1)) dut (.clock_i, .arst_n_i, .cfg_i,
      .timebase_timer_i, .compare_value_i, .pwm_count_i, .unit_io_pin_i, .adc_enabled_i,
      .flag_clear_i, .capture_value_o, .unit_match_flag_o, .unit_io_pin_o, .unit_io_pin_oe_o,
      .events_o, .pwm_duty_o);
   // First unit sees the same inputs; only its converter start must stay low
   ccp_mode_select_decode #(.IS_SECOND_UNIT(1'b0)) dut_first (.clock_i, .arst_n_i, .cfg_i,
      .timebase_timer_i, .compare_value_i, .pwm_count_i, .unit_io_pin_i, .adc_enabled_i,
      .flag_clear_i, .capture_value_o(), .unit_match_flag_o(), .unit_io_pin_o(),
      .unit_io_pin_oe_o(), .events_o(first_events), .pwm_duty_o());
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic int dec(int v);
      return (v < 4) ? 0 : v / 4;
   endfunction
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Inputs move 1 ns after the rising edge, so the falling edge sees settled values
   always @(negedge clock_i) begin
      m = int'(cfg_i.unit_mode_field);
      if (!arst_n_i) begin
         {st, presc, ppin, peq, flg, pin, capv, duty} = '0;
      end else begin
         `CHK("capture", capv, capture_value_o)
         `CHK("flag", flg, unit_match_flag_o)
         `CHK("pin", pin, unit_io_pin_o)
         `CHK("duty", duty, pwm_duty_o)
         cap = st == 1 && dec(m) == 1 && (m == 4 ? ppin && !unit_io_pin_i : !ppin &&
            unit_io_pin_i && (m == 5 || presc == (m == 6 ? 3 : 15)));
         mt = st == 2 && dec(m) == 2 && timebase_timer_i == compare_value_i && !peq;
         evx = {cap, mt, mt && m == 11, mt && m == 11 && adc_enabled_i};
         `CHK("events", evx, events_o)
         `CHK("first unit events", evx & 4'he, first_events)
         if (st == dec(m)) `CHK("oe", st == 3 || (st == 2 && m < 10), unit_io_pin_oe_o)
         flg = cap || mt || (flg && !flag_clear_i);
         if (cap) capv = timebase_timer_i;
         if (mt && m < 10) pin = m == 8;
         if (st == 3) pin = pwm_count_i < duty;
         if (st == 3) duty = {cfg_i.duty_high_byte, cfg_i.duty_low_bits};
         if (st == 0) {capv, duty, pin} = '0;
         presc = (st == 1 && m > 5 && m < 8 && !cap) ? presc + int'(!ppin && unit_io_pin_i) : 0;
         st = dec(m);
         ppin = unit_io_pin_i;
         peq = timebase_timer_i == compare_value_i;
      end
   end
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge clock_i);
      #1 arst_n_i = 1'b1;
      foreach (modes[i]) begin
         repeat (400) begin
            @(posedge clock_i);
            #1 r = rnd();
            cfg_i = {modes[i], r[9:0]};
            unit_io_pin_i = r[12];
            flag_clear_i = r[15:13] == 3'h0;
            adc_enabled_i = r[16];
            if (r[31:26] == 6'h00) compare_value_i = timebase_timer_i + {10'h000, r[21:16]};
         end
      end
      report_and_stop();
   end
endmodule // ccp_mode_select_decode_test
